// ### remote_state_trigger_select_test.sv
// self-checking bench for the remote state / trigger select block
`timescale 1ns/10ps
module remote_state_trigger_select_test;
   logic        clock   = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic        fire    = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, rear_trig_n, keys_locked, local_key_en;
   logic        show_local, show_locked, meas_start, term_cr, term_lf, term_eoi, emul_on, irq;
   logic [31:0] rdat;               // last read data
   logic        rerr;               // last error response
   int          error_cnt = 0;      // mismatches
   int          n_tests   = 0;      // comparisons
   int          cyc       = 0;      // hang guard
   integer      seed      = 32'h34a7f992;

   always #4 clock = ~clock; // 125 MHz

   rsts_top i_dut(.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rear_trig_n(rear_trig_n), .keys_locked(keys_locked), .local_key_en(local_key_en),
      .show_local(show_local), .show_locked(show_locked), .meas_start(meas_start),
      .term_cr(term_cr), .term_lf(term_lf), .term_eoi(term_eoi), .emul_on(emul_on), .irq(irq));
   rsts_rear_src i_rear(.clock(clock), .fire(fire), .rear_trig_n(rear_trig_n));

   ////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic final_report;
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // hang guard, far above the few thousand cycles needed
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         final_report();
      end
   end

   // one apb transfer; waits for pready however long it takes
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // command strobe: code, argument, source bus
   task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic s);
      logic [31:0] d;
      d = 32'h0;
      d[3:0] = c;
      d[11:8] = a;
      d[16] = s;
      apb(1'b1, rsts_pkg::OFF_CMD, d);
   endtask

   // let a mode change reach the outputs
   task automatic settle;
      repeat (4) @(posedge clock);
   endtask

   // cycles until a measurement starts, lim if none; one edge always passes first,
   // so a pulse just seen by the previous wait is not counted twice
   task automatic wait_meas(input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (meas_start !== 1'b1 && n < lim);
   endtask

   // panel outputs packed as {locked, local key, local label, locked label}
   function automatic logic [31:0] front();
      return {28'h0, keys_locked, local_key_en, show_local, show_locked};
   endfunction

   // mode entered by a state command code
   function automatic logic [1:0] exp_mode(input logic [3:0] c);
      case (c)
         4'h1:    return 2'd1;
         4'h2:    return 2'd2;
         4'h4:    return 2'd3;
         default: return 2'd0;
      endcase
   endfunction

   // panel outputs expected in a mode
   function automatic logic [31:0] exp_front(input logic [1:0] m);
      case (m)
         2'd0:    return 32'h4;
         2'd1:    return 32'he;
         2'd2:    return 32'h9;
         default: return 32'h8;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      logic [3:0] codes [4];
      logic [3:0] bad [3];
      logic [31:0] r;
      int n;
      codes = '{4'h2, 4'h1, 4'h4, 4'h3};
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      // power-up state and free-running internal source
      chk(front(), 32'h4);
      apb(1'b0, rsts_pkg::OFF_STATE, 32'h0);
      chk(rdat, 32'h1c4);
      wait_meas(2600, n);
      chk(n < 2600, 1);
      // state command refused while serial is off
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'h0);
      apb(1'b1, rsts_pkg::OFF_STAT, 32'h7);
      cmd(rsts_pkg::CMD_RLOCK, 4'h0, 1'b0);
      settle();
      chk(front(), 32'h4);
      apb(1'b0, rsts_pkg::OFF_STAT, 32'h0);
      chk(rdat & 32'h4, 32'h4);
      // every state command, serial on
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'h1);
      foreach (codes[i])
      begin
         cmd(codes[i], 4'h0, 1'b0);
         settle();
         chk(front(), exp_front(exp_mode(codes[i])));
         apb(1'b0, rsts_pkg::OFF_STATE, 32'h0);
         chk(rdat & 32'h3, exp_mode(codes[i]));
      end
      // out-of-range trigger types: both edges and a random one
      r = $random(seed);
      bad = '{4'h0, 4'hf, 4'h6 + {1'b0, r[2:0]}};
      foreach (bad[i])
      begin
         apb(1'b1, rsts_pkg::OFF_STAT, 32'h7);
         cmd(rsts_pkg::CMD_TRIGTYP, bad[i], r[3]);
         settle();
         apb(1'b0, rsts_pkg::OFF_STATE, 32'h0);
         chk(rdat[5:2], 32'h1);
         apb(1'b0, rsts_pkg::OFF_STAT, 32'h0);
         chk(rdat & 32'h1, 32'h1);
      end
      // each external type answers the rear pin, with or without settling
      for (int t = 2; t <= 5; t++)
      begin
         cmd(rsts_pkg::CMD_TRIGTYP, 4'(t), 1'b0);
         settle();
         apb(1'b0, rsts_pkg::OFF_STATE, 32'h0);
         chk(rdat[5:2], t);
         fire <= 1'b1;
         @(posedge clock);
         fire <= 1'b0;
         wait_meas(400, n);
         chk(n < 400, 1);
         chk(n > 100, (t == 3 || t == 5));
      end
      // no trigger, no measurement
      wait_meas(3000, n);
      chk(n, 3000);
      // bus triggers, with the interrupt armed and then masked
      cmd(rsts_pkg::CMD_TRIGTYP, 4'h4, 1'b0);
      apb(1'b1, rsts_pkg::OFF_MASK, 32'h1 << rsts_pkg::ST_TRIG);
      apb(1'b1, rsts_pkg::OFF_STAT, 32'h7);
      settle();
      chk(irq, 0);
      r = $random(seed);
      cmd(rsts_pkg::CMD_STARTRG, 4'h0, r[0]);
      wait_meas(50, n);
      chk(n < 50, 1);
      settle();
      chk(irq, 1);
      apb(1'b1, rsts_pkg::OFF_STAT, 32'h2);
      settle();
      chk(irq, 0);
      cmd(rsts_pkg::CMD_GETMSG, 4'h0, 1'b0);
      wait_meas(50, n);
      chk(n, 50);
      apb(1'b1, rsts_pkg::OFF_MASK, 32'h0);
      cmd(rsts_pkg::CMD_GETMSG, 4'h0, 1'b1);
      wait_meas(50, n);
      chk(n < 50, 1);
      settle();
      chk(irq, 0);
      apb(1'b0, rsts_pkg::OFF_STAT, 32'h0);
      chk(rdat & 32'h2, 32'h2);
      // unmapped address
      apb(1'b0, 8'h1c, 32'h0);
      chk(rerr, 1);
      chk(rdat, 32'h0);
      // emulation: refused with lan, allowed on the parallel bus alone
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'h6);
      cmd(rsts_pkg::CMD_EMUL, 4'h1, 1'b1);
      settle();
      chk(emul_on, 0);
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'h2);
      cmd(rsts_pkg::CMD_EMUL, 4'h1, 1'b1);
      settle();
      chk(emul_on, 1);
      r = $random(seed);
      cmd(rsts_pkg::CMD_TERMSEL, {1'b0, r[2:0]}, 1'b1);
      settle();
      chk({term_eoi, term_lf, term_cr}, r[2:0]);
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'h3);
      settle();
      chk(emul_on, 0);
      // front panel request on the parallel bus alone, then terminators by register
      apb(1'b1, rsts_pkg::OFF_CTRL, 32'ha);
      settle();
      chk(emul_on, 1);
      apb(1'b1, rsts_pkg::OFF_TERM, {29'h0, ~r[2:0]});
      apb(1'b0, rsts_pkg::OFF_TERM, 32'h0);
      chk(rdat, {29'h0, ~r[2:0]});
      // one internal, four rear, one star and one group trigger started a measurement
      apb(1'b0, rsts_pkg::OFF_TCOUNT, 32'h0);
      chk(rdat, 32'h7);
      final_report();
   end
endmodule

// checker bound inside the design top
bind rsts_top rsts_checker i_chk(.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys_locked(keys_locked),
   .local_key_en(local_key_en), .show_local(show_local), .show_locked(show_locked),
   .meas_start(meas_start), .term_cr(term_cr), .term_lf(term_lf), .term_eoi(term_eoi),
   .emul_on(emul_on));

// ### rsts_checker.sv
// concurrent checks on the ports of the remote state / trigger select block
`timescale 1ns/10ps
module rsts_checker
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rstn,
   // apb slave side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // front panel and measurement
   input wire logic        keys_locked,
   input wire logic        local_key_en,
   input wire logic        show_local,
   input wire logic        show_locked,
   input wire logic        meas_start,
   input wire logic        term_cr,
   input wire logic        term_lf,
   input wire logic        term_eoi,
   input wire logic        emul_on
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   logic [3:0] wr_hist_q; // recent write strobes, a mode change needs one

   // history of accepted apb writes
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         wr_hist_q <= 4'h0;
      else
         wr_hist_q <= {wr_hist_q[2:0], psel & penable & pwrite};
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_emul_off;
      (!emul_on) [*4];
   endsequence
   sequence s_pulse_end;
      meas_start ##1 !meas_start;
   endsequence

   chk_remote_keys: assert property (show_local |-> keys_locked && local_key_en && !show_locked)
      else $error("remote mode front panel outputs wrong");
   chk_rlock_keys: assert property (show_locked |-> keys_locked && !local_key_en)
      else $error("remote lockout leaves a key enabled");
   chk_local_keys: assert property (!keys_locked |-> local_key_en && !show_local && !show_locked)
      else $error("local mode front panel outputs wrong");
   chk_llock_keys: assert property (keys_locked && !show_local |-> !local_key_en)
      else $error("lockout leaves the local key enabled");
   chk_mode_cause: assert property ($changed(keys_locked) |-> wr_hist_q != 4'h0)
      else $error("front panel mode changed without a command");
   chk_meas_pulse: assert property (meas_start |-> s_pulse_end)
      else $error("measurement start longer than one cycle");
   chk_term_hold: assert property (s_emul_off |-> $stable({term_cr, term_lf, term_eoi}))
      else $error("terminators changed outside emulation");
   chk_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error response outside an access cycle");
   chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
      else $error("read data driven outside the answer cycle");
endmodule

// ### rsts_pkg.sv
// constants, register map and types for the remote state / trigger select block
package rsts_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00; // command strobe register (write)
   localparam logic [7:0] OFF_CTRL   = 8'h04; // interface and emulation control
   localparam logic [7:0] OFF_STATE  = 8'h08; // remote/local and trigger state
   localparam logic [7:0] OFF_STAT   = 8'h0c; // sticky event status, write one to clear
   localparam logic [7:0] OFF_MASK   = 8'h10; // interrupt mask
   localparam logic [7:0] OFF_TERM   = 8'h14; // message terminator selection
   localparam logic [7:0] OFF_TCOUNT = 8'h18; // measurement start counter

   // command register fields
   localparam int CMD_CODE_LSB = 0;  // command code
   localparam int CMD_CODE_W   = 4;
   localparam int CMD_ARG_LSB  = 8;  // argument
   localparam int CMD_ARG_W    = 4;
   localparam int CMD_SRC_BIT  = 16; // 1: received on the parallel bus, 0: serial

   // command codes
   localparam logic [3:0] CMD_NONE    = 4'h0;
   localparam logic [3:0] CMD_REMOTE  = 4'h1; // enter_remote_cmd
   localparam logic [3:0] CMD_RLOCK   = 4'h2; // remote_lockout_cmd
   localparam logic [3:0] CMD_LOCAL   = 4'h3; // enter_local_cmd
   localparam logic [3:0] CMD_LLOCK   = 4'h4; // local_lockout_cmd
   localparam logic [3:0] CMD_TRIGTYP = 4'h5; // trigger type, argument 1..5
   localparam logic [3:0] CMD_STARTRG = 4'h6; // star-trigger command
   localparam logic [3:0] CMD_GETMSG  = 4'h7; // group execute trigger message
   localparam logic [3:0] CMD_EMUL    = 4'h8; // emulation on (arg bit0)
   localparam logic [3:0] CMD_TERMSEL = 4'h9; // terminators, arg bits cr/lf/eoi

   // control register fields
   localparam int CTRL_SER_EN  = 0; // serial interface enabled
   localparam int CTRL_GPIB_ACT = 1; // parallel bus interface selected
   localparam int CTRL_LAN_SEL = 2; // lan interface selected
   localparam int CTRL_PANEL_EMUL = 3; // front panel asks for emulation

   // trigger type limits and internal type
   localparam logic [3:0] TRIG_MIN = 4'h1;
   localparam logic [3:0] TRIG_MAX = 4'h5;
   localparam logic [3:0] TRIG_INT = 4'h1;

   // status bits
   localparam int ST_EXEC_ERR = 0; // bad argument
   localparam int ST_TRIG     = 1; // measurement started
   localparam int ST_IGNORED  = 2; // command refused
   localparam int ST_W        = 3;

   // settling delay and internal trigger period
   localparam int CLK_MHZ        = 125;
   localparam int SETTLE_US      = 1;
   localparam int SETTLE_CYC     = SETTLE_US * CLK_MHZ;
   localparam int INT_PERIOD_US  = 20;
   localparam int INT_PERIOD_CYC = INT_PERIOD_US * CLK_MHZ;

   // remote/local modes
   typedef enum logic [1:0]
   {
      RL_LOCAL  = 2'b00,
      RL_REMOTE = 2'b01,
      RL_RLOCK  = 2'b10,
      RL_LLOCK  = 2'b11
   } rsts_rl_t;

   // measurement start sequencer
   typedef enum logic [1:0]
   {
      MS_IDLE   = 2'b00,
      MS_SETTLE = 2'b01,
      MS_START  = 2'b10
   } rsts_ms_t;

endpackage

// ### rsts_rear_src.sv
// host side model: rear panel trigger source and serial settings of the host
`timescale 1ns/10ps
module rsts_rear_src
#(
   parameter int BAUD    = 9600, // host serial rate, no parity, no echo
   parameter int LOW_CYC = 8     // low time of one trigger pulse
)
(
   // clock
   input  wire logic clock,
   // request one falling edge
   input  wire logic fire,
   // pin, pulled up when idle
   output logic      rear_trig_n
);
   int cnt_q = 0; // cycles left in the low phase

   // one negative-going pulse per request
   always @(posedge clock)
   begin
      if (fire)
         cnt_q <= LOW_CYC;
      else if (cnt_q > 0)
         cnt_q <= cnt_q - 1;
   end
   assign rear_trig_n = (cnt_q == 0); // pull-up holds it high between pulses
endmodule

// ### rsts_top.sv
// remote/local state, trigger selection and trigger sources with apb registers
`timescale 1ns/10ps
module rsts_top
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // rear panel trigger pin
   input  wire logic        rear_trig_n,
   // front panel and measurement engine
   output logic             keys_locked,
   output logic             local_key_en,
   output logic             show_local,
   output logic             show_locked,
   output logic             meas_start,
   output logic             term_cr,
   output logic             term_lf,
   output logic             term_eoi,
   output logic             emul_on,
   // interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // settling delay for a trigger type
   function automatic logic type_delays(input logic [3:0] t);
      type_delays = (t == 4'h3) || (t == 4'h5);
   endfunction

   // argument of a command word lies in range
   function automatic logic type_valid(input logic [3:0] t);
      type_valid = (t >= rsts_pkg::TRIG_MIN) && (t <= rsts_pkg::TRIG_MAX);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   logic        wr_en;         // write access phase
   logic        rd_en;         // read access phase
   logic        addr_ok;       // mapped offset
   logic [3:0]  cmd_code;      // decoded command code
   logic [3:0]  cmd_arg;       // command argument
   logic        cmd_par;       // command came from the parallel bus
   logic        cmd_v;         // command strobe

   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && penable && !pwrite;
   assign addr_ok  = (paddr == rsts_pkg::OFF_CMD)   || (paddr == rsts_pkg::OFF_CTRL)
                  || (paddr == rsts_pkg::OFF_STATE) || (paddr == rsts_pkg::OFF_STAT)
                  || (paddr == rsts_pkg::OFF_MASK)  || (paddr == rsts_pkg::OFF_TERM)
                  || (paddr == rsts_pkg::OFF_TCOUNT);
   assign cmd_v    = wr_en && (paddr == rsts_pkg::OFF_CMD);
   assign cmd_code = pwdata[rsts_pkg::CMD_CODE_LSB +: rsts_pkg::CMD_CODE_W];
   assign cmd_arg  = pwdata[rsts_pkg::CMD_ARG_LSB +: rsts_pkg::CMD_ARG_W];
   assign cmd_par  = pwdata[rsts_pkg::CMD_SRC_BIT];
   // commands arrive already tokenised, so spaced, comma and packed forms all map alike

   ////////////////////////////////////////////////////////////////////////////
   // control register

   logic [3:0] ctrl_q;         // serial en, parallel active, lan select, panel emulation

   // software-written interface selection
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ctrl_q <= 4'h0;
      else if (wr_en && paddr == rsts_pkg::OFF_CTRL)
         ctrl_q <= pwdata[3:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // remote/local state

   rsts_pkg::rsts_rl_t rl_q;   // current remote/local mode
   logic               rl_ok;  // state commands are accepted

   assign rl_ok = ctrl_q[rsts_pkg::CTRL_SER_EN];

   // state changes only while serial interface is on
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rl_q <= rsts_pkg::RL_LOCAL;
      else if (cmd_v && rl_ok)
      begin
         unique case (cmd_code)
            rsts_pkg::CMD_REMOTE: rl_q <= rsts_pkg::RL_REMOTE;
            rsts_pkg::CMD_RLOCK:  rl_q <= rsts_pkg::RL_RLOCK;
            rsts_pkg::CMD_LOCAL:  rl_q <= rsts_pkg::RL_LOCAL;
            rsts_pkg::CMD_LLOCK:  rl_q <= rsts_pkg::RL_LLOCK;
            default:              rl_q <= rl_q;
         endcase
      end
   end

   // front panel outputs registered from the mode
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         keys_locked  <= 1'b0;
         local_key_en <= 1'b1;
         show_local   <= 1'b0;
         show_locked  <= 1'b0;
      end
      else
      begin
         keys_locked  <= (rl_q != rsts_pkg::RL_LOCAL);
         local_key_en <= (rl_q == rsts_pkg::RL_LOCAL) || (rl_q == rsts_pkg::RL_REMOTE);
         show_local   <= (rl_q == rsts_pkg::RL_REMOTE);
         show_locked  <= (rl_q == rsts_pkg::RL_RLOCK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger type

   logic [3:0] ttype_q;        // selected trigger type 1..5
   logic       is_state_cmd;   // command is one of the four state commands
   logic       type_bad;       // trigger type command with bad argument

   assign is_state_cmd = (cmd_code == rsts_pkg::CMD_REMOTE) || (cmd_code == rsts_pkg::CMD_RLOCK)
                      || (cmd_code == rsts_pkg::CMD_LOCAL)  || (cmd_code == rsts_pkg::CMD_LLOCK);
   assign type_bad     = cmd_v && (cmd_code == rsts_pkg::CMD_TRIGTYP) && !type_valid(cmd_arg);

   // a bad argument leaves the old type in place
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ttype_q <= rsts_pkg::TRIG_INT;
      else if (cmd_v && cmd_code == rsts_pkg::CMD_TRIGTYP && type_valid(cmd_arg))
         ttype_q <= cmd_arg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // emulation mode and terminators

   logic emul_ok;              // emulation may be chosen

   assign emul_ok = ctrl_q[rsts_pkg::CTRL_GPIB_ACT] && !ctrl_q[rsts_pkg::CTRL_SER_EN]
                 && !ctrl_q[rsts_pkg::CTRL_LAN_SEL];

   // emulation falls away once the parallel bus is no longer the only interface (serial or lan on, or bus off)
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         emul_on <= 1'b0;
      else if (!emul_ok)
         emul_on <= 1'b0;
      else if (cmd_v && cmd_code == rsts_pkg::CMD_EMUL)
         emul_on <= cmd_arg[0];
      else if (ctrl_q[rsts_pkg::CTRL_PANEL_EMUL])
         emul_on <= 1'b1;
   end

   // terminators, each its own bit, only settable in emulation
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         term_cr  <= 1'b1;
         term_lf  <= 1'b1;
         term_eoi <= 1'b1;
      end
      else if (emul_on && ((cmd_v && cmd_code == rsts_pkg::CMD_TERMSEL)
                        || (wr_en && paddr == rsts_pkg::OFF_TERM)))
      begin
         term_cr  <= (paddr == rsts_pkg::OFF_TERM) ? pwdata[0] : cmd_arg[0];
         term_lf  <= (paddr == rsts_pkg::OFF_TERM) ? pwdata[1] : cmd_arg[1];
         term_eoi <= (paddr == rsts_pkg::OFF_TERM) ? pwdata[2] : cmd_arg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rear trigger pin synchroniser and edge

   logic rear_s1_q;            // first stage, read only by the second
   logic rear_s2_q;            // second stage
   logic rear_s3_q;            // previous level for edge detect
   logic rear_fall;            // falling edge seen

   // two stages, then edge history
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rear_s1_q <= 1'b1;
         rear_s2_q <= 1'b1;
         rear_s3_q <= 1'b1;
      end
      else
      begin
         rear_s1_q <= rear_trig_n;
         rear_s2_q <= rear_s1_q;
         rear_s3_q <= rear_s2_q;
      end
   end

   assign rear_fall = rear_s3_q && !rear_s2_q;

   ////////////////////////////////////////////////////////////////////////////
   // internal trigger source

   logic [15:0] int_cnt_q;     // period counter
   logic        int_tick;      // internal trigger pulse

   // free-running while internal type is chosen
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         int_cnt_q <= 16'h0000;
      else if (ttype_q != rsts_pkg::TRIG_INT || int_tick)
         int_cnt_q <= 16'h0000;
      else
         int_cnt_q <= int_cnt_q + 16'h0001;
   end

   assign int_tick = (ttype_q == rsts_pkg::TRIG_INT)
                  && (int_cnt_q == 16'(rsts_pkg::INT_PERIOD_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   // trigger selection

   logic ext_sel;              // any external type
   logic bus_trig;             // trigger command from a bus
   logic trig_ev;              // trigger from the selected source

   assign ext_sel  = (ttype_q != rsts_pkg::TRIG_INT);
   // star-trigger from either bus, group trigger only from the parallel bus
   assign bus_trig = cmd_v && ((cmd_code == rsts_pkg::CMD_STARTRG)
                            || (cmd_code == rsts_pkg::CMD_GETMSG && cmd_par));
   // rear pin enabled for types 2..5 alike; no serial line source exists
   assign trig_ev  = ext_sel ? (rear_fall || bus_trig) : int_tick;

   ////////////////////////////////////////////////////////////////////////////
   // measurement start sequencer

   rsts_pkg::rsts_ms_t ms_q;    // sequencer state
   logic [7:0]         settle_q; // settling counter

   // triggers during settling are dropped, the pending one is already queued
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ms_q     <= rsts_pkg::MS_IDLE;
         settle_q <= 8'h00;
      end
      else
      begin
         unique case (ms_q)
            rsts_pkg::MS_IDLE:
               if (trig_ev)
               begin
                  settle_q <= 8'h00;
                  ms_q     <= type_delays(ttype_q) ? rsts_pkg::MS_SETTLE : rsts_pkg::MS_START;
               end
            rsts_pkg::MS_SETTLE:
               if (settle_q == 8'(rsts_pkg::SETTLE_CYC - 1))
                  ms_q <= rsts_pkg::MS_START;
               else
                  settle_q <= settle_q + 8'h01;
            rsts_pkg::MS_START:
               ms_q <= rsts_pkg::MS_IDLE;
            default:
               ms_q <= rsts_pkg::MS_IDLE;
         endcase
      end
   end

   // one-cycle start pulse to the measurement engine
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         meas_start <= 1'b0;
      else
         meas_start <= (ms_q == rsts_pkg::MS_START);
   end

   logic [15:0] tcount_q;      // number of starts

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         tcount_q <= 16'h0000;
      else if (ms_q == rsts_pkg::MS_START)
         tcount_q <= tcount_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask

   logic [2:0] stat_q;         // sticky events
   logic [2:0] mask_q;         // enable per event
   logic [2:0] stat_set;       // events this cycle
   logic [2:0] stat_clr;       // write-one-to-clear

   assign stat_set[rsts_pkg::ST_EXEC_ERR] = type_bad;
   assign stat_set[rsts_pkg::ST_TRIG]     = (ms_q == rsts_pkg::MS_START);
   assign stat_set[rsts_pkg::ST_IGNORED]  = cmd_v && is_state_cmd && !rl_ok;
   assign stat_clr = (wr_en && paddr == rsts_pkg::OFF_STAT) ? pwdata[2:0] : 3'h0;

   // set beats clear in the same cycle
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         stat_q <= 3'h0;
      else
         stat_q <= (stat_q & ~stat_clr) | stat_set;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         mask_q <= 3'h0;
      else if (wr_en && paddr == rsts_pkg::OFF_MASK)
         mask_q <= pwdata[2:0];
   end

   // level interrupt from a flop
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer, no wait state, with outputs still taken from flops

   logic [31:0] rd_mux;        // read data select

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         rsts_pkg::OFF_CTRL:   rd_mux = {28'h0, ctrl_q};
         rsts_pkg::OFF_STATE:  rd_mux = {22'h0, emul_on, term_eoi, term_lf, term_cr, ttype_q, rl_q};
         rsts_pkg::OFF_STAT:   rd_mux = {29'h0, stat_q};
         rsts_pkg::OFF_MASK:   rd_mux = {29'h0, mask_q};
         rsts_pkg::OFF_TERM:   rd_mux = {29'h0, term_eoi, term_lf, term_cr};
         rsts_pkg::OFF_TCOUNT: rd_mux = {16'h0, tcount_q};
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   // pready rises in the first access cycle and drops after
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

endmodule
